// file: verilog/pio_periph.sv
// Peripheral-side programmed I/O interface driving the processor backplane
//
// Notes on behaviour
// - Output data is captured only on the leading edge of timing pulse 3.
// - HHH outputs accumulator unchanged; LHH (line 0 grounded) outputs then clears.
// - HLH ORs peripheral data into accumulator; LLH loads accumulator from bus.
// - Line 0 ignored: HL adds data to counter; LL loads counter from bus.
// - Control line 2 grounded 280 ns before strobe, 400 ns for relative jump.
// - Data valid 280 ns before strobe, 400 ns for relative jumps.
// - Flag set on a skip test grounds skip 50 ns before timing pulse 3.
// - Interrupt request asserted at once whenever the device flag is set and i_irq_enable is high.
// - Extended transfer asserts transfer-continues 50 ns before timing pulse 3.
// - Extended transfer: wait 400 ns after data, then strobe low 100 ns.
// - Selected interface asserts the internal I/O claim line.
// - Data and memory data lines are active low.
module pio_periph #(
	parameter logic [5:0] DEV_CODE = pio_pkg::DEV_CODE_DEF, // Device select code
	parameter int         TIMER_W  = 4                      // Setup timer width
) (
	input  wire logic                        i_clk,           // 10 MHz clock
	input  wire logic                        i_reset,         // Sync reset, high
	// Backplane
	input  wire logic                        i_io_pause_n,    // I/O pause, low active
	input  wire logic [11:0]                 i_md_n,          // Memory data, bit 11 = line 0
	input  wire logic                        i_timing_pulse_3, // Timing pulse 3, high
	input  wire logic [11:0]                 i_data_n,        // Data bus in, low = 1
	output logic      [11:0]                 o_data_n,        // Data bus out value
	output logic                             o_data_oe,       // Data bus drive enable
	output pio_pkg::drive_s                  o_od_oe,         // Open-drain ground enables
	output pio_pkg::drive_s                  o_od_n,          // Open-drain values, all low
	// User side
	input  wire logic                        i_flag_set,      // Device event, pulse
	input  wire logic                        i_irq_enable,    // Interrupt enable, level
	input  wire pio_pkg::mode_e              i_mode,          // Transfer kind
	input  wire logic [11:0]                 i_in_data,       // Word to processor
	output logic                             o_flag,          // Device flag
	output logic      [11:0]                 o_out_data,      // Word from processor
	output logic                             o_out_valid,     // Output word pulse
	output logic                             o_in_taken       // Input loaded pulse
);

	// ------------------------------------------------------------
	// Elaboration checks
	// ------------------------------------------------------------
	if ((2 ** TIMER_W) <= pio_pkg::REL_CYC) begin : g_chk
		$error("TIMER_W too small for the relative jump setup");
	end

	typedef enum logic [2:0] {
		ST_IDLE,
		ST_ACTIVE,
		ST_RELEASE,
		ST_STROBE,
		ST_DONE
	} state_e;

	state_e             state_r, state_nxt;
	pio_pkg::mode_e     mode_r;
	logic [2:0]         op_r;
	logic [11:0]        data_drv_r;
	logic [TIMER_W-1:0] timer_r;
	logic               pulse3_d_r;
	logic               stall_r;
	logic               flag_r;
	logic [11:0]        out_data_r;
	logic               out_valid_r;
	logic               in_taken_r;

	// ------------------------------------------------------------
	// Decode
	// ------------------------------------------------------------
	wire logic [11:0] md_word  = ~i_md_n;
	wire logic        pause    = ~i_io_pause_n;
	wire logic        selected = pause
		&& md_word[pio_pkg::OPC_LSB +: 3] == pio_pkg::OPC_IO
		&& md_word[pio_pkg::DEV_LSB +: pio_pkg::DEV_W] == DEV_CODE;
	wire logic        pulse3_rise = i_timing_pulse_3 && !pulse3_d_r;
	wire logic        in_xfer  = state_r == ST_ACTIVE || state_r == ST_RELEASE
		|| state_r == ST_STROBE;
	wire logic        xfer_op  = op_r[pio_pkg::OP_XFER_BIT];
	wire logic        drive_ok = in_xfer && pause;
	wire logic        is_rel   = mode_r == pio_pkg::MODE_JUMP_REL;
	wire logic        is_out   = mode_r == pio_pkg::MODE_OUT_KEEP
		|| mode_r == pio_pkg::MODE_OUT_CLEAR;
	wire logic        rel_ready = stall_r && timer_r >= TIMER_W'(pio_pkg::REL_CYC);

	// Ground pattern per kind; bit 0 is control line 0
	function automatic logic [2:0] ctl_code(input pio_pkg::mode_e m);
		unique case (m)
			pio_pkg::MODE_OUT_KEEP:  ctl_code = 3'h0;
			pio_pkg::MODE_OUT_CLEAR: ctl_code = 3'h1;
			pio_pkg::MODE_IN_OR:     ctl_code = 3'h2;
			pio_pkg::MODE_IN_JAM:    ctl_code = 3'h3;
			pio_pkg::MODE_JUMP_REL:  ctl_code = 3'h4;
			pio_pkg::MODE_JUMP_ABS:  ctl_code = 3'h6;
			default:                 ctl_code = 3'h0;
		endcase
	endfunction

	// ------------------------------------------------------------
	// Sequencer
	// ------------------------------------------------------------
	always_comb begin
		state_nxt = state_r;
		unique case (state_r)
			ST_IDLE:    if (selected) state_nxt = ST_ACTIVE;
			ST_ACTIVE: begin
				if (!pause)
					state_nxt = ST_IDLE;
				else if (xfer_op && is_rel && rel_ready)
					state_nxt = ST_RELEASE;
			end
			// Continues must be high before our own strobe
			ST_RELEASE: state_nxt = pause ? ST_STROBE : ST_IDLE;
			ST_STROBE:  state_nxt = ST_DONE;
			ST_DONE:    if (!pause) state_nxt = ST_IDLE;
			default:    state_nxt = ST_IDLE;
		endcase
	end

	always_ff @(posedge i_clk) begin
		if (i_reset) begin
			state_r    <= ST_IDLE;
			pulse3_d_r <= 1'b0;
		end else begin
			state_r    <= state_nxt;
			pulse3_d_r <= i_timing_pulse_3;
		end
	end

	// Kind, op and data are frozen for the whole instruction
	always_ff @(posedge i_clk) begin
		if (i_reset) begin
			mode_r     <= pio_pkg::MODE_OUT_KEEP;
			op_r       <= 3'h0;
			data_drv_r <= 12'hfff;
		end else if (state_r == ST_IDLE && selected) begin
			mode_r     <= i_mode;
			op_r       <= md_word[2:0];
			data_drv_r <= ~i_in_data;
		end
	end

	// Counts cycles that data has stood on the bus
	always_ff @(posedge i_clk) begin
		if (i_reset || state_r == ST_IDLE)
			timer_r <= '0;
		else if (timer_r != '1)
			timer_r <= timer_r + TIMER_W'(1);
	end

	always_ff @(posedge i_clk) begin
		if (i_reset || state_r == ST_IDLE)
			stall_r <= 1'b0;
		else if (pulse3_rise)
			stall_r <= 1'b1;
	end

	// ------------------------------------------------------------
	// Flag, output buffer, input acknowledge
	// ------------------------------------------------------------
	wire logic clr_flag = state_r == ST_ACTIVE && pulse3_rise && op_r[pio_pkg::OP_CLR_BIT];

	always_ff @(posedge i_clk) begin
		if (i_reset)
			flag_r <= pio_pkg::FLAG_RST;
		else if (i_flag_set)
			flag_r <= 1'b1;
		else if (clr_flag)
			flag_r <= 1'b0;
	end

	wire logic out_cap  = state_r == ST_ACTIVE && pulse3_rise && xfer_op && is_out;
	wire logic in_norm  = state_r == ST_ACTIVE && pulse3_rise && xfer_op && !is_out && !is_rel;

	always_ff @(posedge i_clk) begin
		if (i_reset) begin
			out_data_r  <= 12'h000;
			out_valid_r <= 1'b0;
			in_taken_r  <= 1'b0;
		end else begin
			if (out_cap)
				out_data_r <= ~i_data_n;
			out_valid_r <= out_cap;
			in_taken_r  <= in_norm || state_r == ST_STROBE;
		end
	end

	// ------------------------------------------------------------
	// Pin drives
	// ------------------------------------------------------------
	always_comb begin
		o_od_oe                   = '0;
		o_od_oe.xfer_ctl          = (drive_ok && xfer_op) ? ctl_code(mode_r) : 3'h0;
		o_od_oe.skip              = state_r == ST_ACTIVE && pause && flag_r
			&& op_r[pio_pkg::OP_SKIP_BIT];
		o_od_oe.interrupt_request = flag_r && i_irq_enable;
		o_od_oe.io_claim          = selected;
		o_od_oe.transfer_continues = state_r == ST_ACTIVE && pause && xfer_op && is_rel;
		o_od_oe.bus_strobe        = state_r == ST_STROBE && pause;
	end

	assign o_od_n      = '0;
	assign o_data_n    = data_drv_r;
	assign o_data_oe   = drive_ok && xfer_op && !is_out;
	assign o_flag      = flag_r;
	assign o_out_data  = out_data_r;
	assign o_out_valid = out_valid_r;
	assign o_in_taken  = in_taken_r;

	// ------------------------------------------------------------
	// Assertions
	// ------------------------------------------------------------
	default clocking cb @(posedge i_clk); endclocking
	default disable iff (i_reset);

	a_out_capture_edge: assert property (
		state_r == ST_ACTIVE && pulse3_rise && xfer_op && is_out
		|=> o_out_valid && o_out_data == ~$past(i_data_n))
		else $error("output word not captured at pulse 3 edge");

	a_release_after_pause: assert property (!pause |->
		!o_data_oe && o_od_oe.xfer_ctl == 3'h0 && !o_od_oe.skip)
		else $error("bus still driven outside the I/O pause");

	a_ctl_only_selected: assert property (o_od_oe.xfer_ctl != 3'h0 |->
		state_r != ST_IDLE && $past(state_r) != ST_IDLE || $past(selected))
		else $error("control lines driven while not selected");

	a_ctl_abs_code: assert property (
		o_od_oe.xfer_ctl != 3'h0 && mode_r == pio_pkg::MODE_JUMP_ABS
		|-> o_od_oe.xfer_ctl == 3'h6 && o_data_oe)
		else $error("absolute jump control code wrong");

	a_strobe_setup_data: assert property ($rose(o_od_oe.bus_strobe) |->
		$past(o_data_oe, 1) && $past(o_data_oe, 5) && !o_od_oe.transfer_continues)
		else $error("strobe without 400 ns of data setup");

	a_strobe_width_one: assert property (
		$rose(o_od_oe.bus_strobe) |=> !o_od_oe.bus_strobe)
		else $error("strobe not exactly one cycle");

	a_cont_before_pulse: assert property (
		pulse3_rise && state_r == ST_ACTIVE && xfer_op && is_rel && pause
		|-> o_od_oe.transfer_continues)
		else $error("continues not asserted ahead of pulse 3");

	a_irq_follows_flag: assert property (i_flag_set && i_irq_enable
		|=> o_od_oe.interrupt_request && o_flag)
		else $error("interrupt request not raised with flag");

	a_skip_on_flag: assert property (o_od_oe.skip |-> o_flag
		&& $past(state_r == ST_ACTIVE || selected))
		else $error("skip grounded without flag");

	a_claim_selected: assert property (selected |-> o_od_oe.io_claim)
		else $error("claim not asserted when selected");

	c_rel_jump: cover property ($rose(o_od_oe.bus_strobe) ##2 state_r == ST_IDLE);
	c_out_word: cover property (o_out_valid);
	c_skip_taken: cover property (o_od_oe.skip && pulse3_rise);
	c_flag_race: cover property (i_flag_set && clr_flag);
	c_abs_load: cover property (o_in_taken && mode_r == pio_pkg::MODE_JUMP_ABS);

	a_in_or_code: assert property (
		o_od_oe.xfer_ctl != 3'h0 && mode_r == pio_pkg::MODE_IN_OR
		|-> o_od_oe.xfer_ctl == 3'h2 && o_data_oe)
		else $error("inclusive-or input control code wrong");

	a_in_jam_code: assert property (
		o_od_oe.xfer_ctl != 3'h0 && mode_r == pio_pkg::MODE_IN_JAM
		|-> o_od_oe.xfer_ctl == 3'h3 && o_data_oe)
		else $error("jam input control code wrong");

	a_rel_jump_code: assert property (
		o_od_oe.xfer_ctl != 3'h0 && mode_r == pio_pkg::MODE_JUMP_REL
		|-> o_od_oe.xfer_ctl == 3'h4 && o_data_oe)
		else $error("relative jump control code wrong");

	a_out_clear_code: assert property (
		drive_ok && xfer_op && mode_r == pio_pkg::MODE_OUT_CLEAR
		|-> o_od_oe.xfer_ctl == 3'h1 && !o_data_oe)
		else $error("clearing output control code wrong");

	// Line 2 must already be grounded well ahead of our own strobe
	a_ctl2_setup: assert property ($rose(o_od_oe.bus_strobe) |->
		$past(o_od_oe.xfer_ctl[2], 1) && $past(o_od_oe.xfer_ctl[2], 4))
		else $error("control line 2 not grounded ahead of strobe");

	a_flag_set_wins: assert property (i_flag_set |=> o_flag)
		else $error("flag event lost");

	a_strobe_rel_only: assert property (o_od_oe.bus_strobe |->
		mode_r == pio_pkg::MODE_JUMP_REL && $past(state_r) == ST_RELEASE)
		else $error("own strobe outside a relative jump");

	a_in_taken_pulse: assert property (o_in_taken |=> !o_in_taken)
		else $error("input acknowledge longer than one cycle");

endmodule

// file: verilog/pio_pkg.sv
// Package: constants, modes and pin bundles of the programmed I/O interface
package pio_pkg;

	// ------------------------------------------------------------
	// Timing
	// ------------------------------------------------------------
	localparam int CLK_PERIOD_NS = 100;
	localparam int T_SETUP_NS    = 280;
	localparam int T_REL_NS      = 400;
	localparam int T_STROBE_NS   = 100;
	localparam int T_LEAD_NS     = 50;
	// Least times round up, the strobe width rounds down, none below one cycle
	localparam int SETUP_CYC  = (T_SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int REL_CYC    = (T_REL_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int STROBE_CYC = (T_STROBE_NS / CLK_PERIOD_NS < 1) ? 1
		: T_STROBE_NS / CLK_PERIOD_NS;
	localparam int LEAD_CYC   = (T_LEAD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

	// ------------------------------------------------------------
	// Instruction word fields (bit 11 is memory data line 0)
	// ------------------------------------------------------------
	localparam int          WORD_W      = 12;
	localparam int          OPC_LSB     = 9;
	localparam logic [2:0]  OPC_IO      = 3'h6;
	localparam int          DEV_LSB     = 3;
	localparam int          DEV_W       = 6;
	localparam int          OP_SKIP_BIT = 0;
	localparam int          OP_XFER_BIT = 1;
	localparam int          OP_CLR_BIT  = 2;
	localparam logic [5:0]  DEV_CODE_DEF = 6'h2a;
	localparam logic        FLAG_RST    = 1'b0;

	typedef enum logic [2:0] {
		MODE_OUT_KEEP,
		MODE_OUT_CLEAR,
		MODE_IN_OR,
		MODE_IN_JAM,
		MODE_JUMP_REL,
		MODE_JUMP_ABS
	} mode_e;

	// Open-drain enables; high grounds the line
	typedef struct packed {
		logic [2:0] xfer_ctl;
		logic       skip;
		logic       interrupt_request;
		logic       io_claim;
		logic       transfer_continues;
		logic       bus_strobe;
	} drive_s;

endpackage

// file: tb/pio_cpu_model.sv
// Processor-side model: I/O pause, timing pulse 3, bus strobe and register loads
module pio_cpu_model (
	input  wire logic            i_clk,    // 10 MHz clock
	input  wire pio_pkg::drive_s i_od_oe,  // Interface ground enables
	input  wire logic [11:0]     i_dev_n,  // Interface data drive value
	input  wire logic            i_dev_oe, // Interface data drive enable
	output logic                 o_pause_n, // I/O pause, low active
	output logic [11:0]          o_md_n,   // Memory data lines
	output logic                 o_pulse3, // Timing pulse 3
	output logic [11:0]          o_bus_n   // Resolved data bus level
);
	timeunit 1ns;
	timeprecision 1ns;

	logic [11:0] accumulator;
	logic [11:0] pc;
	logic [2:0]  ctl_seen;
	logic        skipped;
	logic        int_seen;
	logic        claim_seen;
	logic        stall;
	logic        hung;
	wire         ctl0_gnd = i_od_oe.xfer_ctl[0];
	wire         ctl1_gnd = i_od_oe.xfer_ctl[1];
	wire         ctl2_gnd = i_od_oe.xfer_ctl[2];
	wire         cpu_drv  = !o_pause_n && !ctl2_gnd && !(ctl0_gnd && ctl1_gnd);
	// Pulled-up bus: any grounding party wins
	assign o_bus_n = (i_dev_oe ? i_dev_n : 12'hfff) & (cpu_drv ? ~accumulator : 12'hfff);

	initial begin
		o_pause_n = 1'b1;
		o_md_n    = 12'hfff;
		o_pulse3  = 1'b0;
		accumulator = 12'h000;
		pc        = 12'h000;
		hung      = 1'b0;
	end

	task automatic load_regs(input logic [11:0] d);
		if (ctl2_gnd)
			pc = ctl1_gnd ? d : pc + d;
		else if (ctl1_gnd)
			accumulator = ctl0_gnd ? d : (accumulator | d);
		else if (ctl0_gnd)
			accumulator = 12'h000;
	endtask

	task automatic run_instr(input logic [11:0] word);
		int n;
		@(posedge i_clk);
		#1 o_pause_n = 1'b0;
		o_md_n = ~word;
		repeat (5) @(posedge i_clk);
		#1 o_pulse3 = 1'b1;
		skipped    = i_od_oe.skip;
		int_seen   = i_od_oe.interrupt_request;
		claim_seen = i_od_oe.io_claim;
		ctl_seen   = i_od_oe.xfer_ctl;
		stall      = i_od_oe.transfer_continues;
		@(posedge i_clk);
		#1 o_pulse3 = 1'b0;
		n = 0;
		if (stall) begin
			while (!i_od_oe.bus_strobe && n < 40) begin
				@(posedge i_clk);
				#1 n++;
			end
			hung = i_od_oe.transfer_continues || n == 40;
		end else begin
			@(posedge i_clk);
			#1;
		end
		load_regs(~o_bus_n);
		@(posedge i_clk);
		#1 o_pause_n = 1'b1;
		o_md_n = word;
	endtask
endmodule

// file: tb/programmed_io_transfer_control_test.sv
// Self-checking bench for the peripheral programmed I/O interface
module programmed_io_transfer_control_test;
	timeunit 1ns;
	timeprecision 1ns;

	localparam logic [11:0] IO_WORD = {3'h6, pio_pkg::DEV_CODE_DEF, 3'h0};
	localparam logic [11:0] A0  = 12'h5a3;
	localparam logic [11:0] D0  = 12'h0c6;
	localparam logic [11:0] P0  = 12'h7f0;

	logic            clk = 1'b0;
	logic            reset = 1'b1;
	logic            pause_n;
	logic [11:0]     md_n;
	logic            pulse3;
	logic [11:0]     bus_n;
	logic [11:0]     data_n;
	logic            data_oe;
	pio_pkg::drive_s od_oe;
	pio_pkg::drive_s od_n;
	logic            flag_set = 1'b0;
	logic            irq_enable = 1'b0;
	pio_pkg::mode_e  mode = pio_pkg::MODE_OUT_KEEP;
	logic [11:0]     in_data = 12'h000;
	logic            flag;
	logic [11:0]     out_data;
	logic            out_valid;
	logic            in_taken;
	int              failures = 0;
	int              cmp_count = 0;
	int              valid_cnt = 0;
	int              taken_cnt = 0;
	logic [11:0]     exp_acc [6] = '{A0, 12'h000, A0 | D0, D0, A0, A0};
	logic [11:0]     exp_pc [6] = '{P0, P0, P0, P0, P0 + D0, D0};

	pio_periph u_pio_periph (.i_clk(clk), .i_reset(reset), .i_io_pause_n(pause_n),
		.i_md_n(md_n), .i_timing_pulse_3(pulse3), .i_data_n(bus_n), .o_data_n(data_n),
		.o_data_oe(data_oe), .o_od_oe(od_oe), .o_od_n(od_n), .i_flag_set(flag_set),
		.i_irq_enable(irq_enable), .i_mode(mode), .i_in_data(in_data), .o_flag(flag),
		.o_out_data(out_data), .o_out_valid(out_valid), .o_in_taken(in_taken));
	pio_cpu_model u_pio_cpu_model (.i_clk(clk), .i_od_oe(od_oe), .i_dev_n(data_n),
		.i_dev_oe(data_oe), .o_pause_n(pause_n), .o_md_n(md_n), .o_pulse3(pulse3),
		.o_bus_n(bus_n));

	initial begin
		forever #50 clk = ~clk;
	end

	always @(posedge clk) begin
		if (out_valid === 1'b1)
			valid_cnt++;
		if (in_taken === 1'b1)
			taken_cnt++;
	end

	task automatic check(input string what, input logic [11:0] seen, input logic [11:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			failures++;
			$display("MISMATCH %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task automatic complete_run();
		if (failures == 0 && cmp_count > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask

	task automatic exec_instr(input logic [11:0] word);
		u_pio_cpu_model.run_instr(word);
		repeat (2) @(posedge clk);
		#1;
		if (u_pio_cpu_model.hung) begin
			failures++;
			complete_run();
		end
	endtask

	task automatic raise_flag();
		@(posedge clk);
		#1 flag_set = 1'b1;
		@(posedge clk);
		#1 flag_set = 1'b0;
	endtask

	// ------------------------------------------------------------
	// Main sequence
	// ------------------------------------------------------------
	initial begin
		int v0;
		int t0;
		repeat (5) @(posedge clk);
		#1 reset = 1'b0;
		check("idle drives", 12'({od_oe, data_oe}), 12'h000);
		check("ground value", 12'(od_n), 12'h000);
		for (int m = 0; m < 6; m++) begin
			mode = pio_pkg::mode_e'(m);
			in_data = D0;
			u_pio_cpu_model.accumulator = A0;
			u_pio_cpu_model.pc = P0;
			v0 = valid_cnt;
			t0 = taken_cnt;
			exec_instr(IO_WORD | 12'h002);
			check("acc", u_pio_cpu_model.accumulator, exp_acc[m]);
			check("pc", u_pio_cpu_model.pc, exp_pc[m]);
			check("claim", 12'(u_pio_cpu_model.claim_seen), 12'h001);
			check("out pulses", 12'(valid_cnt - v0), 12'(m < 2));
			check("in pulses", 12'(taken_cnt - t0), 12'(m >= 2));
			if (m < 2)
				check("out word", out_data, A0);
			check("released", 12'({od_oe, data_oe}), 12'h000);
		end
		// Another device's code must leave the bus alone
		mode = pio_pkg::MODE_IN_JAM;
		u_pio_cpu_model.accumulator = A0;
		exec_instr({3'h6, ~pio_pkg::DEV_CODE_DEF, 3'h2});
		check("foreign acc", u_pio_cpu_model.accumulator, A0);
		check("foreign ctl", 12'(u_pio_cpu_model.ctl_seen), 12'h000);
		// Skip and interrupt, with the interrupt enabled then masked
		irq_enable = 1'b1;
		raise_flag();
		check("irq", 12'(od_oe.interrupt_request), 12'h001);
		exec_instr(IO_WORD | 12'h005);
		check("skip set", 12'(u_pio_cpu_model.skipped), 12'h001);
		check("flag clr", 12'(flag), 12'h000);
		exec_instr(IO_WORD | 12'h001);
		check("skip clear", 12'(u_pio_cpu_model.skipped), 12'h000);
		irq_enable = 1'b0;
		raise_flag();
		exec_instr(IO_WORD | 12'h001);
		check("skip masked", 12'(u_pio_cpu_model.skipped), 12'h001);
		check("irq masked", 12'(u_pio_cpu_model.int_seen), 12'h000);
		check("flag kept", 12'(flag), 12'h001);
		complete_run();
	end
endmodule
